// file: hw/sacc_defines.svh
/*
  Timing counts and field constants for the conversion control block.
  Assumes a 50 MHz mclk (20 ns period).
*/
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

`define SACC_CLK_PERIOD_NS   20
`define SACC_DATA_W          16
// Conversion phase length in ns and cycles (longest time, rounds down)
`define SACC_CONV_TIME_NS    7000
`define SACC_CONV_CYC        (`SACC_CONV_TIME_NS / `SACC_CLK_PERIOD_NS)
// Least acquisition time in ns and cycles (rounds up)
`define SACC_ACQ_TIME_NS     2800
`define SACC_ACQ_CYC         ((`SACC_ACQ_TIME_NS + `SACC_CLK_PERIOD_NS - 1) \
                              / `SACC_CLK_PERIOD_NS)
`define SACC_CNT_W           10
// Sign bit flipped to turn offset binary into two's complement
`define SACC_SIGN_MASK       16'h8000

`endif

// file: hw/sacc_pkg.sv
/*
  Types for the conversion control block.
  Assumes sacc_defines.svh is on the include path.
*/
`include "sacc_defines.svh"
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_CONV,
    SACC_ACQ
  } sacc_state_e;
  typedef logic [`SACC_DATA_W-1:0] sacc_word_t;
  typedef logic [`SACC_CNT_W-1:0]  sacc_cnt_t;
endpackage : sacc_pkg

// file: hw/sacc_ctrl.sv
/*
  Conversion sequencing and output gating for a 16-bit sampling converter.
  Assumes mclk at 50 MHz, sys_rst asynchronous active high; pins
  conversion_start_n, power_down_input, cs_n, rd_n and the selects come
  from outside and are synchronised here. The raw SAR result arrives on
  sar_result, sampled at the end of the conversion phase.
*/
`include "sacc_defines.svh"

module sacc_ctrl
  import sacc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       conversion_start_n,
  input  wire logic       power_down_input,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       output_coding_select,
  input  wire logic       serial_parallel_select,
  input  wire sacc_word_t sar_result,
  output logic            busy,
  output logic            low_power,
  output logic            powered_down,
  output sacc_word_t      data_out,
  output sacc_word_t      data_oe,
  output logic            serial_active
);

  // Two-stage synchronisers for every pin input
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
    end else begin
      sync1_reg <= {conversion_start_n, power_down_input, cs_n, rd_n,
                    output_coding_select, serial_parallel_select};
      sync2_reg <= sync1_reg;
    end
  end

  logic start_n_s;
  logic pd_s;
  logic cs_n_s;
  logic rd_n_s;
  logic ob_s;
  logic ser_s;
  assign start_n_s = sync2_reg[5];
  assign pd_s      = sync2_reg[4];
  assign cs_n_s    = sync2_reg[3];
  assign rd_n_s    = sync2_reg[2];
  assign ob_s      = sync2_reg[1];
  assign ser_s     = sync2_reg[0];

  // Output coding: ob high gives straight binary, low gives two's complement
  function automatic sacc_word_t sacc_code(input sacc_word_t raw,
                                           input logic straight);
    sacc_code = straight ? raw : (raw ^ `SACC_SIGN_MASK);
  endfunction : sacc_code

  // Conversion sequencer state
  sacc_state_e state_reg;
  sacc_state_e state_next;
  sacc_cnt_t   cnt_reg;
  sacc_cnt_t   cnt_next;
  logic        pd_reg;
  logic        pd_next;
  sacc_word_t  result_reg;
  sacc_word_t  result_next;

  // Next-state logic; start is not gated by cs_n or rd_n at all
  always_comb begin
    state_next        = state_reg;
    cnt_next          = cnt_reg;
    pd_next           = pd_reg;
    result_next       = result_reg;
    case (state_reg)
      SACC_IDLE: begin
        // Falling start edge, or start already low, begins a conversion
        if (!start_n_s && !pd_s) begin
          state_next = SACC_CONV;
          cnt_next   = '0;
          pd_next    = 1'b0;
        end else begin
          pd_next = pd_s;
        end
      end
      SACC_CONV: begin
        // Nothing here looks at start or power-down: no abort path
        if (cnt_reg == sacc_cnt_t'(`SACC_CONV_CYC - 1)) begin
          result_next = sacc_code(sar_result, ob_s);
          state_next  = SACC_ACQ;
          cnt_next    = '0;
        end else begin
          cnt_next = cnt_reg + sacc_cnt_t'(1);
        end
      end
      SACC_ACQ: begin
        // Self-timed acquisition; rate is internal, so it may run fast
        if (cnt_reg != sacc_cnt_t'(`SACC_ACQ_CYC - 1)) begin
          cnt_next = cnt_reg + sacc_cnt_t'(1);
        end else if (!start_n_s && !pd_s) begin
          state_next = SACC_CONV;
          cnt_next   = '0;
        end else begin
          state_next = SACC_IDLE;
          pd_next    = pd_s;
        end
      end
      default: begin
        state_next = SACC_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg        <= SACC_IDLE;
      cnt_reg          <= '0;
      pd_reg           <= 1'b0;
      result_reg       <= 16'h0000;
    end else begin
      state_reg        <= state_next;
      cnt_reg          <= cnt_next;
      pd_reg           <= pd_next;
      result_reg       <= result_next;
    end
  end

  // Busy and power state; result is latched on the same edge that busy drops
  assign busy         = (state_reg == SACC_CONV);
  assign low_power    = (state_reg != SACC_CONV);
  assign powered_down = pd_reg;

  // Serial shifter on the shared pin, reloaded when a read window opens
  logic       read_en;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic       rd_win_reg;
  logic       rd_win_next;
  // Interface gating ignores the sequencer state, so it runs in acquisition
  assign read_en = !cs_n_s && !rd_n_s;

  always_comb begin
    rd_win_next = read_en;
    bit_next    = bit_reg;
    if (read_en && !rd_win_reg) begin
      bit_next = 4'hF;
    end else if (read_en && ser_s) begin
      bit_next = bit_reg - 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_reg    <= 4'hF;
      rd_win_reg <= 1'b0;
    end else begin
      bit_reg    <= bit_next;
      rd_win_reg <= rd_win_next;
    end
  end

  // Data pins: parallel word, or serial bit on pin 0 only
  sacc_word_t data_out_next;
  sacc_word_t data_oe_next;
  always_comb begin
    data_out_next = 16'h0000;
    data_oe_next  = 16'h0000;
    if (read_en) begin
      if (ser_s) begin
        data_out_next[0] = result_reg[bit_next];
        data_oe_next     = 16'h0001;
      end else begin
        data_out_next = result_reg;
        data_oe_next  = 16'hFFFF;
      end
    end
  end

  sacc_word_t data_out_reg;
  sacc_word_t data_oe_reg;
  logic       serial_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out_reg <= 16'h0000;
      data_oe_reg  <= 16'h0000;
      serial_reg   <= 1'b0;
    end else begin
      data_out_reg <= data_out_next;
      data_oe_reg  <= data_oe_next;
      serial_reg   <= read_en && ser_s;
    end
  end

  assign data_out      = data_out_reg;
  assign data_oe       = data_oe_reg;
  assign serial_active = serial_reg;

endmodule : sacc_ctrl

// file: tb/sacc_ctrl_props.sv
/* Port checker for sacc_ctrl.
   Assumes the bind below and the timing counts in sacc_defines.svh. */
`include "sacc_defines.svh"
module sacc_ctrl_props
  import sacc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       conversion_start_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       serial_parallel_select,
  input wire logic       busy,
  input wire logic       low_power,
  input wire logic       powered_down,
  input wire sacc_word_t data_oe,
  input wire logic       serial_active
);
  localparam int CONV = `SACC_CONV_CYC;
  localparam int ACQ  = `SACC_ACQ_CYC;
  sacc_cnt_t hi_reg;
  sacc_cnt_t lo_reg;
  // Busy run lengths; lo saturates so the first start is not held back
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_reg <= '0;
      lo_reg <= 10'h3FF;
    end else begin
      hi_reg <= busy ? hi_reg + 1'b1 : '0;
      lo_reg <= busy ? '0 : lo_reg + 10'(lo_reg != 10'h3FF);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_low_power_idle: assert property (low_power == !busy)
    else $error("low_power is not the inverse of busy");
  a_conv_full_length: assert property ($fell(busy) |-> hi_reg == CONV)
    else $error("conversion ended early");
  a_conv_no_stretch: assert property (hi_reg <= CONV)
    else $error("conversion ran too long");
  a_acq_gap_kept: assert property ($rose(busy) |-> lo_reg >= ACQ)
    else $error("conversion restarted inside acquisition");
  a_free_run_restart: assert property ($fell(busy) && !conversion_start_n
    |-> ##[1:200] (busy || conversion_start_n))
    else $error("no automatic restart");
  a_pd_waits_idle: assert property (busy |-> !$rose(powered_down))
    else $error("power-down entered during conversion");
  a_oe_needs_sel: assert property ((|data_oe)
    |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("bus driven while deselected");
  a_oe_opens_par: assert property
    ((!cs_n && !rd_n && !serial_parallel_select)[*5]
    |-> data_oe == 16'hFFFF)
    else $error("parallel read not driven");
  a_serial_excl: assert property ((!serial_parallel_select)[*5]
    |-> !serial_active)
    else $error("serial window in parallel mode");
endmodule : sacc_ctrl_props

bind sacc_ctrl sacc_ctrl_props u_props (.mclk, .sys_rst,
  .conversion_start_n, .cs_n, .rd_n, .serial_parallel_select, .busy,
  .low_power, .powered_down, .data_oe, .serial_active);

// file: tb/sacc_bus_model.sv
/* Host view of the shared data bus.
   Assumes data_out and data_oe come from sacc_ctrl. */
module sacc_bus_model
  import sacc_pkg::*;
(
  input  wire logic       mclk,
  input  wire sacc_word_t data_out,
  input  wire sacc_word_t data_oe,
  output sacc_word_t      bus
);
  timeunit 1ns;
  timeprecision 1ns;
  sacc_word_t last_reg;
  // Released bits flip each cycle so a stale value never reads as good
  always_ff @(posedge mclk) last_reg <= bus;
  assign bus = (data_oe & data_out) | (~data_oe & ~last_reg);
endmodule : sacc_bus_model

// file: tb/sacc_ctrl_bench.sv
/* Self-checking bench for sacc_ctrl.
   Assumes the checker and bus model are compiled before it. */
`include "sacc_defines.svh"
module sacc_ctrl_bench
  import sacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, sys_rst = 1'h1, conversion_start_n = 1'h1;
  logic power_down_input = 1'h0, cs_n = 1'h1, rd_n = 1'h1;
  logic output_coding_select = 1'h1, serial_parallel_select = 1'h0;
  logic busy, low_power, powered_down, serial_active;
  sacc_word_t sar_result = 16'h0, data_out, data_oe, bus, got;
  int bad_count = 0, check_count = 0, n;
  sacc_ctrl u_dut (.*);
  sacc_bus_model u_host (.*);
  initial forever #10 mclk = ~mclk;
  task automatic check(input sacc_word_t seen, input sacc_word_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Start one conversion, pulse power-down inside it, count busy width
  task automatic convert(input sacc_word_t raw, input logic hold);
    // Start stays high a full acquisition span before it is pulled low
    repeat (`SACC_ACQ_CYC) @(negedge mclk);
    sar_result = raw;
    conversion_start_n = 1'h0;
    n = 0;
    while (busy !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    conversion_start_n = hold ? 1'h0 : 1'h1;
    n = 0;
    while (busy === 1'h1 && n < 400) begin
      @(negedge mclk);
      power_down_input = (n == 50);
      n++;
    end
  endtask : convert
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge mclk);
    check(data_oe, 16'h0);
    sys_rst = 1'h0;
    // Both codings, read strobes high while converting
    for (int k = 0; k < 2; k++) begin
      output_coding_select = k[0];
      convert(16'h1234, 1'h0);
      check(16'(n), 16'(`SACC_CONV_CYC));
      cs_n = 1'h0;
      rd_n = 1'h0;
      repeat (4) @(negedge mclk);
      check(bus, k ? 16'h1234 : 16'h9234);
      cs_n = 1'h1;
      repeat (4) @(negedge mclk);
      check(data_oe, 16'h0);
      rd_n = 1'h1;
    end
    // Start held low runs on its own
    convert(16'h0001, 1'h1);
    n = 0;
    while (busy !== 1'h1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    check(16'(n), 16'(`SACC_ACQ_CYC));
    conversion_start_n = 1'h1;
    repeat (400) @(negedge mclk);
    // Serial read, MSB first on the shared line
    serial_parallel_select = 1'h1;
    convert(16'hA5C3, 1'h0);
    cs_n = 1'h0;
    rd_n = 1'h0;
    n = 0;
    while (serial_active !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    for (int b = 0; b < 16; b++) begin
      got = {got[14:0], bus[0]};
      @(negedge mclk);
    end
    check(got, 16'hA5C3);
    // Power-down raised during acquisition holds off starts
    power_down_input = 1'h1;
    conversion_start_n = 1'h0;
    // Acquisition must run out before power-down can be taken
    repeat (200) @(negedge mclk);
    check(powered_down, 1'h1);
    check(busy, 1'h0);
    tally_and_finish();
  end
endmodule : sacc_ctrl_bench
